// ### bench/smb_far.sv
// Far-side model: static memory, I/O and NAND parts on the shared bus.
// Assumes the bench resolves the data wire, with a pull-up when undriven.
`timescale 1ns/10ps
`default_nettype none
module smb_far
	import smb_pkg::*;
(
	input wire logic clk_in, // System clock.
	input wire logic [SEL_W-1:0] sel_n_in, // Selects, active low.
	input wire logic oe_n_in, // Read output enable.
	input wire logic [1:0] wr_n_in, // Lane write enables.
	input wire logic nrd_n_in, // NAND read strobe.
	input wire logic nwr_n_in, // NAND write strobe.
	input wire logic [1:0] nlat_in, // NAND latches.
	input wire logic [ADDR_W-1:0] addr_in, // Address bus.
	input wire logic [DATA_W-1:0] bus_in, // Data wire level.
	input wire logic [3:0] wait_len_in, // Wait cycles per access.
	input wire logic [3:0] busy_len_in, // NAND busy cycles.
	input wire logic busy_go_in, // Starts a busy period.
	output logic drive_out, // Model drives the wire.
	output logic [DATA_W-1:0] data_out, // Drive value.
	output logic wait_n_out, // Wait, active low.
	output logic [1:0] rb_n_out // Ready, low when busy.
);
	logic [DATA_W-1:0] mem [0:2047]; // Words by select and low address.
	logic [10:0] idx; // Word index.
	logic [3:0] wcnt = 4'h0; // Wait cycles left.
	logic [3:0] bcnt = 4'h0; // Busy cycles left.
	logic sel; // Some part is selected.
	logic strobe; // Output enable or a lane write enable is low.
	// Picks the word from the low select and, except for NAND, the low address byte.
	always_comb begin
		idx = 11'h000;
		for (int i = 0; i < SEL_W; i++) begin
			if (!sel_n_in[i]) idx = (i >= SEL_NAND0) ? {3'(i), 8'h00} : {3'(i), addr_in[7:0]};
		end
	end
	assign sel = ~&sel_n_in;
	assign strobe = !oe_n_in || !(&wr_n_in);
	assign drive_out = sel && (!oe_n_in || !nrd_n_in);
	assign data_out = drive_out ? mem[idx] : 16'hFFFF;
	// Wait stays low for a set number of strobe cycles, so the access stretches.
	assign wait_n_out = !(sel && wcnt != 4'h0);
	// Both NAND parts report busy for a set number of cycles.
	assign rb_n_out = {2{bcnt == 4'h0}};
	// Stores lanes under their enables and counts wait and busy cycles.
	always @(posedge clk_in) begin
		if (sel && !wr_n_in[0]) mem[idx][7:0] <= bus_in[7:0];
		if (sel && !wr_n_in[1]) mem[idx][15:8] <= bus_in[15:8];
		if (sel && !nwr_n_in && nlat_in == 2'h0) mem[idx] <= bus_in;
		wcnt <= !sel ? wait_len_in : wcnt - 4'(strobe && wcnt != 4'h0);
		bcnt <= busy_go_in ? busy_len_in : bcnt - 4'(bcnt != 4'h0);
	end
endmodule
`default_nettype wire

// ### bench/tb_static_memory_nand_bus_port.sv
// Bench for the static memory port: queued expectations, pin monitors.
// Assumes the far-side model smb_far and a 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_static_memory_nand_bus_port
	import smb_pkg::*;
;
	typedef struct {logic err; logic rd; logic ac; logic [15:0] data;
		logic [23:0] addr; logic [14:0] mask; int lat;} smb_note_s;
	logic clk_in, rstn_in, req_in, write_in, nand_bank_in, bus8_in, swap_in, b8;
	logic boot_active_in, boot_nand_in, busy_go, busy_out, ack_out, err_out, wait_n, drv;
	logic shared_data_bus_oe_n_out, mem_bank0_select_n_out, mem_bank1_select_n_out;
	logic io_bank0_select_n_out, io_bank1_select_n_out, io_bank2_select_n_out;
	logic ext_output_enable_n_out, low_byte_write_n_out, high_byte_write_n_out;
	logic nand_cmd_latch_out, nand_addr_latch_out, nand_bank0_enable_n_out;
	logic nand_bank1_enable_n_out, nand_read_strobe_n_out, nand_write_strobe_n_out;
	logic [1:0] target_in, nand_op_in, be_in, rb_n, pce;
	logic [3:0] split_in, wait_len, busy_len, sp;
	logic [ADDR_W-1:0] addr_in, shared_address_bus_out, a;
	logic [DATA_W-1:0] wdata_in, rdata_out, shared_data_bus_out, bus, mdata, d, rnd;
	logic [SEL_W-1:0] sel_n;
	logic [14:0] seen, cur;
	int cnt, n_mismatch, num_checks;
	smb_note_s q[$];
	smb_note_s nt;
	assign sel_n = {nand_bank1_enable_n_out, nand_bank0_enable_n_out, io_bank2_select_n_out,
		io_bank1_select_n_out, io_bank0_select_n_out, mem_bank1_select_n_out,
		mem_bank0_select_n_out};
	assign cur = {~shared_data_bus_oe_n_out, ~nand_write_strobe_n_out, ~nand_read_strobe_n_out,
		nand_addr_latch_out, nand_cmd_latch_out, ~high_byte_write_n_out,
		~low_byte_write_n_out, ~ext_output_enable_n_out, ~sel_n};
	// The data wire has a pull-up, so it reads high when nobody drives it.
	assign bus = !shared_data_bus_oe_n_out ? shared_data_bus_out : (drv ? mdata : 16'hFFFF);
	smb_port u_dut (.clk_in, .rstn_in, .req_in, .write_in, .target_in, .nand_op_in,
		.nand_bank_in, .addr_in, .wdata_in, .be_in, .bus8_in, .split_in, .swap_in,
		.boot_active_in, .boot_nand_in, .busy_out, .ack_out, .err_out, .rdata_out,
		.shared_data_bus_in(bus), .shared_data_bus_out, .shared_data_bus_oe_n_out,
		.shared_address_bus_out, .mem_bank0_select_n_out, .mem_bank1_select_n_out,
		.io_bank0_select_n_out, .io_bank1_select_n_out, .io_bank2_select_n_out,
		.ext_wait_n_in(wait_n), .ext_output_enable_n_out, .low_byte_write_n_out,
		.high_byte_write_n_out, .nand_cmd_latch_out, .nand_addr_latch_out,
		.nand_bank0_enable_n_out, .nand_bank1_enable_n_out, .nand_read_strobe_n_out,
		.nand_write_strobe_n_out, .nand_ready_busy_n_in(rb_n));
	smb_far u_far (.clk_in, .sel_n_in(sel_n), .oe_n_in(ext_output_enable_n_out),
		.wr_n_in({high_byte_write_n_out, low_byte_write_n_out}),
		.nrd_n_in(nand_read_strobe_n_out), .nwr_n_in(nand_write_strobe_n_out),
		.nlat_in({nand_addr_latch_out, nand_cmd_latch_out}), .addr_in(shared_address_bus_out),
		.bus_in(bus), .wait_len_in(wait_len), .busy_len_in(busy_len), .busy_go_in(busy_go),
		.drive_out(drv), .data_out(mdata), .wait_n_out(wait_n), .rb_n_out(rb_n));
	// Makes the 50 MHz clock.
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	// Steps the random source.
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Compares one value and counts the outcome.
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Notes the expected result, then makes one request and waits for its ack.
	task automatic acc(input logic [1:0] tg, input logic wr, input logic [1:0] op,
		input logic nb, input logic [23:0] ad, input logic [15:0] dt, input logic [1:0] b,
		input int si, input logic [15:0] ex, input int lat);
		smb_note_s n;
		logic w;
		int k;
		w = wr | (tg == TGT_NAND && op != NOP_DATA);
		n.err = (si < 0);
		n.rd = !w && si >= 0;
		n.ac = si >= 0 && tg != TGT_NAND;
		n.data = ex;
		n.addr = (tg == TGT_IO) ? {10'h000, ad[13:0]} : ad;
		n.lat = lat;
		n.mask = 15'h0000;
		if (si >= 0) begin
			n.mask[si] = 1'b1;
			if (tg == TGT_NAND) n.mask[w ? 13 : 12] = 1'b1;
			else if (!w) n.mask[7] = 1'b1;
			else n.mask[9:8] = b8 ? 2'h1 : b;
			n.mask[14] = w;
			n.mask[10] = tg == TGT_NAND && op == NOP_CMD;
			n.mask[11] = tg == TGT_NAND && op == NOP_ADDR;
		end
		q.push_back(n);
		{req_in, write_in, nand_bank_in, target_in, nand_op_in} <= {1'b1, wr, nb, tg, op};
		{addr_in, wdata_in, be_in} <= {ad, dt, b};
		@(posedge clk_in);
		req_in <= 1'b0;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (ack_out !== 1'b1 && k < 200);
		if (ack_out !== 1'b1) n_mismatch++;
	endtask
	// Watches every edge: one select at most, idle pins, no fight on the wire.
	always @(posedge clk_in) begin
		if (rstn_in) begin
			chk(24'($countones(~sel_n) > 1), 24'h0);
			if (busy_out === 1'b0) chk({sel_n, cur[14:7]}, {7'h7F, 8'h00});
			chk(24'(!shared_data_bus_oe_n_out && drv), 24'h0);
			for (int i = 0; i < 2; i++) begin
				if (pce[i] && !sel_n[SEL_NAND0 + i]) chk(24'(rb_n[i]), 24'h1);
			end
		end
		pce <= sel_n[6:5];
		seen <= (req_in && !busy_out) ? 15'h0000 : seen | cur;
		cnt <= (req_in && !busy_out) ? 0 : cnt + 1;
	end
	// Takes the oldest note whenever an ack appears and compares.
	always @(posedge clk_in) begin
		if (rstn_in && ack_out === 1'b1 && q.size() > 0) begin
			nt = q.pop_front();
			chk(24'(err_out), 24'(nt.err));
			chk(24'(seen), 24'(nt.mask));
			if (nt.rd) chk(24'(rdata_out), 24'(nt.data));
			if (nt.ac) chk(shared_address_bus_out, nt.addr);
			if (nt.lat > 0 || nt.err) chk(24'(cnt), 24'(nt.lat));
			if (nt.lat < 0) chk(24'(cnt >= -nt.lat), 24'h1);
		end else if (rstn_in && ack_out === 1'b1) chk(24'h1, 24'h0);
	end
	// Cuts a hang short.
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
	// Main sequence of scenarios.
	initial begin
		{req_in, write_in, nand_bank_in, bus8_in, swap_in, boot_active_in, b8} = '0;
		{boot_nand_in, busy_go, target_in, nand_op_in, addr_in, wdata_in} = '0;
		{be_in, split_in, wait_len, busy_len, rstn_in} = {2'h3, 4'h8, 4'h0, 4'h0, 1'b0};
		{rnd, n_mismatch, num_checks} = {16'h002A, 32'h0, 32'h0};
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		chk(24'(rdata_out), 24'h0);
		// Bank mapping over random split points and both swap settings.
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			sp = rnd[3:0];
			{split_in, swap_in} <= {sp, i[0]};
			rnd = lfsr(rnd);
			a = {rnd, rnd[15:8]};
			d = lfsr(rnd);
			acc(TGT_MEM, 1, NOP_CMD, 0, a, d, 2'h3, int'((a[23:20] >= sp) ^ i[0]), 0, 5);
			acc(TGT_MEM, 0, NOP_CMD, 0, a, 0, 2'h3, int'((a[23:20] >= sp) ^ i[0]), d, 5);
		end
		// Boot from memory forces bank 0; boot from NAND forces NAND bank 0.
		{boot_active_in, split_in, swap_in} <= {1'b1, 4'h0, 1'b0};
		acc(TGT_MEM, 1, NOP_CMD, 0, 24'hF00010, 16'h0F0F, 2'h3, SEL_MEM0, 0, 5);
		boot_nand_in <= 1'b1;
		acc(TGT_NAND, 1, NOP_CMD, 1, 0, 16'h0090, 2'h3, SEL_NAND0, 0, 0);
		{boot_active_in, boot_nand_in, split_in} <= {2'h0, 4'h8};
		// Lane enables, then byte mode.
		acc(TGT_MEM, 1, NOP_CMD, 0, 24'h000042, 16'h1234, 2'h3, SEL_MEM0, 0, 5);
		acc(TGT_MEM, 1, NOP_CMD, 0, 24'h000042, 16'hABCD, 2'h2, SEL_MEM0, 0, 5);
		acc(TGT_MEM, 0, NOP_CMD, 0, 24'h000042, 0, 2'h3, SEL_MEM0, 16'hAB34, 5);
		b8 = 1'b1;
		bus8_in <= b8;
		acc(TGT_MEM, 1, NOP_CMD, 0, 24'h000042, 16'h5566, 2'h3, SEL_MEM0, 0, 5);
		acc(TGT_MEM, 0, NOP_CMD, 0, 24'h000042, 0, 2'h3, SEL_MEM0, 16'h0066, 5);
		b8 = 1'b0;
		bus8_in <= b8;
		// External wait stretches a read.
		wait_len <= 4'h3;
		acc(TGT_MEM, 0, NOP_CMD, 0, 24'h000042, 0, 2'h3, SEL_MEM0, 16'hAB66, -6);
		wait_len <= 4'h0;
		// Each I/O bank, then the unused bank and the unused target.
		for (int b = 0; b < 3; b++) begin
			rnd = lfsr(rnd);
			a = {rnd[7:0], 2'(b), rnd[13:0]};
			d = lfsr(rnd);
			acc(TGT_IO, 1, NOP_CMD, 0, a, d, 2'h3, SEL_IO0 + b, 0, 5);
			acc(TGT_IO, 0, NOP_CMD, 0, a, 0, 2'h3, SEL_IO0 + b, d, 5);
		end
		acc(TGT_IO, 1, NOP_CMD, 0, 24'h00C010, 16'h1111, 2'h3, -1, 0, 0);
		acc(2'h3, 0, NOP_CMD, 0, 24'h000010, 0, 2'h3, -1, 0, 0);
		// Every NAND operation on both banks; each write follows a busy period.
		for (int nb = 0; nb < 2; nb++) begin
			for (int op = 0; op < 3; op++) begin
				{busy_len, busy_go} <= {4'h4, 1'b1};
				@(posedge clk_in);
				busy_go <= 1'b0;
				rnd = lfsr(rnd);
				d = rnd;
				acc(TGT_NAND, 1, 2'(op), 1'(nb), 0, d, 2'h3, SEL_NAND0 + nb, 0, 0);
			end
			acc(TGT_NAND, 0, NOP_DATA, 1'(nb), 0, 0, 2'h3, SEL_NAND0 + nb, d, 0);
		end
		repeat (4) @(posedge clk_in);
		summarize();
	end
endmodule
`default_nettype wire

// ### verilog/smb_decode.sv
// Address decoder turning a request into one select line, or an error flag.
// Assumes inputs are stable while the port samples them.
`timescale 1ns/10ps
`default_nettype none
module smb_decode
	import smb_pkg::*;
(
	input wire logic [1:0] target_in, // Kind of access.
	input wire logic [ADDR_W-1:0] addr_in, // Request address.
	input wire logic [3:0] split_in, // Top nibble where the upper range starts.
	input wire logic swap_in, // Swaps which bank serves which range.
	input wire logic boot_active_in, // Boot phase is running.
	input wire logic boot_nand_in, // Boot from NAND instead of memory.
	input wire logic nand_bank_in, // Requested NAND bank.
	output logic [SEL_W-1:0] sel_out, // One-hot select, active high.
	output logic bad_out // Request hits no bank.
);
	// Decodes the target and address into one select, or none with bad_out set.
	always_comb begin
		sel_out = '0;
		bad_out = 1'b0;
		case (target_in)
			TGT_MEM: begin
				// Range at or above the split goes to bank 1 unless swapped.
				if (boot_active_in && !boot_nand_in) begin
					sel_out[SEL_MEM0] = 1'b1; // R8
				end else if ((addr_in[ADDR_W-1 -: 4] >= split_in) ^ swap_in) begin
					sel_out[SEL_MEM1] = 1'b1; // R7 R6
				end else begin
					sel_out[SEL_MEM0] = 1'b1; // R7 R6
				end
			end
			TGT_IO: begin
				// Two bits just above the 16 KB offset pick the bank.
				case (addr_in[IO_OFFS_W+1 -: 2])
					2'h0: sel_out[SEL_IO0] = 1'b1; // R4 R5
					2'h1: sel_out[SEL_IO1] = 1'b1; // R4 R5
					2'h2: sel_out[SEL_IO2] = 1'b1; // R4 R5
					default: bad_out = 1'b1;
				endcase
			end
			TGT_NAND: begin
				// Boot from NAND forces bank 0.
				if ((boot_active_in && boot_nand_in) || !nand_bank_in) begin
					sel_out[SEL_NAND0] = 1'b1; // R16 R15
				end else begin
					sel_out[SEL_NAND1] = 1'b1; // R15
				end
			end
			default: bad_out = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// ### verilog/smb_pkg.sv
// Constants, state type and decode codes for the static memory port.
// Assumes a single 50 MHz clock; every time below becomes a cycle count.
// Function
// [R1] Two-way 16-bit data bus for reads, writes.
// [R2] Eight-bit bus width for memory and I/O.
// [R3] One shared data bus, one access at a time.
// [R4] Three I/O banks, one select each.
// [R5] Each I/O bank limited to 16 KB.
// [R6] Two memory banks, one select each.
// [R7] Configurable address ranges map to memory banks.
// [R8] Memory bank 0 selectable as boot source.
// [R9] Wait input low stretches the current access; the code ignores it for NAND accesses.
// [R10] Output enable low during memory, I/O reads.
// [R11] High byte write enable qualifies upper lane.
// [R12] Low write enable qualifies low lane, byte mode.
// [R13] Command latch high while command on bus.
// [R14] Address latch high while address on bus.
// [R15] Two NAND enables, only accessed one low.
// [R16] NAND bank 0 selectable as boot source.
// [R17] Read strobe fetches each NAND byte.
// [R18] 24-bit shared address bus.
// [R19] Write strobe latches each NAND byte.
// [R20] Wait for NAND ready before its access.
// [R21] All selects idle high; never two at once.
// [R22] Bus driven only on writes, else released.
package smb_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20; // Clock period in ns.
	localparam int unsigned ADDR_W = 24; // Shared address width.
	localparam int unsigned DATA_W = 16; // Shared data width.
	localparam int unsigned IO_OFFS_W = 14; // Offset bits inside one I/O bank.
	localparam int unsigned SEL_W = 7; // Number of select lines.
	localparam int unsigned SEL_MEM0 = 0; // Memory bank 0 select index.
	localparam int unsigned SEL_MEM1 = 1; // Memory bank 1 select index.
	localparam int unsigned SEL_IO0 = 2; // I/O bank 0 select index.
	localparam int unsigned SEL_IO1 = 3; // I/O bank 1 select index.
	localparam int unsigned SEL_IO2 = 4; // I/O bank 2 select index.
	localparam int unsigned SEL_NAND0 = 5; // NAND bank 0 enable index.
	localparam int unsigned SEL_NAND1 = 6; // NAND bank 1 enable index.
	localparam int unsigned SETUP_NS = 20; // Select to strobe setup time.
	localparam int unsigned STROBE_NS = 60; // Least strobe width.
	localparam int unsigned HOLD_NS = 20; // Strobe release to deselect.
	localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [1:0] TGT_MEM = 2'h0; // Memory bank access.
	localparam logic [1:0] TGT_IO = 2'h1; // External I/O access.
	localparam logic [1:0] TGT_NAND = 2'h2; // NAND flash access.
	localparam logic [1:0] NOP_CMD = 2'h0; // NAND command byte.
	localparam logic [1:0] NOP_ADDR = 2'h1; // NAND address byte.
	localparam logic [1:0] NOP_DATA = 2'h2; // NAND data byte.
	localparam logic [ADDR_W-1:0] RST_ADDR = 24'h000000; // Address after reset.
	localparam logic [DATA_W-1:0] RST_DATA = 16'h0000; // Data after reset.
	typedef enum logic [2:0] {S_IDLE, S_NWAIT, S_SETUP, S_STROBE, S_HOLD} smb_state_e;
endpackage

// ### verilog/smb_port.sv
// Static memory, I/O and NAND bus port with one access engine.
// Assumes pins and user inputs are synchronous to clk_in.
`timescale 1ns/10ps
`default_nettype none
module smb_port
	import smb_pkg::*;
(
	input wire logic clk_in, // System clock.
	input wire logic rstn_in, // Asynchronous reset, active low.
	input wire logic req_in, // Access request, taken when idle.
	input wire logic write_in, // One for write, zero for read.
	input wire logic [1:0] target_in, // Memory, I/O or NAND.
	input wire logic [1:0] nand_op_in, // NAND command, address or data.
	input wire logic nand_bank_in, // NAND bank number.
	input wire logic [ADDR_W-1:0] addr_in, // Access address.
	input wire logic [DATA_W-1:0] wdata_in, // Write data.
	input wire logic [1:0] be_in, // Byte enables for 16-bit writes.
	input wire logic bus8_in, // Eight-bit bus mode.
	input wire logic [3:0] split_in, // Memory range split nibble.
	input wire logic swap_in, // Swap memory bank ranges.
	input wire logic boot_active_in, // Boot phase running.
	input wire logic boot_nand_in, // Boot source is NAND.
	output logic busy_out, // Engine busy.
	output logic ack_out, // One-cycle completion pulse.
	output logic err_out, // Completion was a decode error.
	output logic [DATA_W-1:0] rdata_out, // Read data.
	input wire logic [DATA_W-1:0] shared_data_bus_in, // Data bus level.
	output logic [DATA_W-1:0] shared_data_bus_out, // Data bus drive value.
	output logic shared_data_bus_oe_n_out, // Low while driving the bus.
	output logic [ADDR_W-1:0] shared_address_bus_out, // Address bus.
	output logic mem_bank0_select_n_out, // Memory bank 0 select.
	output logic mem_bank1_select_n_out, // Memory bank 1 select.
	output logic io_bank0_select_n_out, // I/O bank 0 select.
	output logic io_bank1_select_n_out, // I/O bank 1 select.
	output logic io_bank2_select_n_out, // I/O bank 2 select.
	input wire logic ext_wait_n_in, // External wait, active low.
	output logic ext_output_enable_n_out, // Read output enable.
	output logic low_byte_write_n_out, // Low lane write enable.
	output logic high_byte_write_n_out, // High lane write enable.
	output logic nand_cmd_latch_out, // NAND command latch enable.
	output logic nand_addr_latch_out, // NAND address latch enable.
	output logic nand_bank0_enable_n_out, // NAND bank 0 enable.
	output logic nand_bank1_enable_n_out, // NAND bank 1 enable.
	output logic nand_read_strobe_n_out, // NAND read strobe.
	output logic nand_write_strobe_n_out, // NAND write strobe.
	input wire logic [1:0] nand_ready_busy_n_in // NAND ready, low when busy.
);
	smb_state_e state, next_state; // Engine state.
	logic [3:0] cnt, next_cnt; // Phase cycle counter.
	logic wr, next_wr; // Latched direction.
	logic b8, next_b8; // Latched byte mode.
	logic [1:0] tgt, next_tgt; // Latched target.
	logic [1:0] op, next_op; // Latched NAND operation.
	logic [1:0] be, next_be; // Latched byte enables.
	logic [SEL_W-1:0] sel, next_sel; // Latched one-hot select.
	logic [SEL_W-1:0] sel_n, next_sel_n; // Select pins, active low.
	logic [ADDR_W-1:0] next_addr; // Next address bus value.
	logic [DATA_W-1:0] next_wdat; // Next data bus value.
	logic [DATA_W-1:0] next_rdata; // Next read data.
	logic next_ack, next_err, next_busy; // Next handshake outputs.
	logic next_doe_n, next_oe_n, next_lo_n, next_hi_n; // Next strobes.
	logic next_cle, next_ale, next_re_n, next_we_n; // Next NAND strobes.
	logic [SEL_W-1:0] dec_sel; // Decoded select for the request.
	logic dec_bad; // Request decodes to nothing.
	logic rb_ready; // Selected NAND bank is ready.
	logic active, strobe, mio; // Next-state helpers.

	// Decoder for the incoming request.
	smb_decode u_dec (
		.target_in(target_in),
		.addr_in(addr_in),
		.split_in(split_in),
		.swap_in(swap_in),
		.boot_active_in(boot_active_in),
		.boot_nand_in(boot_nand_in),
		.nand_bank_in(nand_bank_in),
		.sel_out(dec_sel),
		.bad_out(dec_bad)
	);

	// Ready line of the NAND bank that the latched access targets.
	assign rb_ready = sel[SEL_NAND1] ? nand_ready_busy_n_in[1] : nand_ready_busy_n_in[0];

	// Select pins come straight from the select flip-flops.
	assign mem_bank0_select_n_out = sel_n[SEL_MEM0];
	assign mem_bank1_select_n_out = sel_n[SEL_MEM1];
	assign io_bank0_select_n_out = sel_n[SEL_IO0];
	assign io_bank1_select_n_out = sel_n[SEL_IO1];
	assign io_bank2_select_n_out = sel_n[SEL_IO2];
	assign nand_bank0_enable_n_out = sel_n[SEL_NAND0];
	assign nand_bank1_enable_n_out = sel_n[SEL_NAND1];

	// Next-state logic of the engine and of every pin it drives.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_wr = wr;
		next_b8 = b8;
		next_tgt = tgt;
		next_op = op;
		next_be = be;
		next_sel = sel;
		next_addr = shared_address_bus_out;
		next_wdat = shared_data_bus_out;
		next_rdata = rdata_out;
		next_ack = 1'b0;
		next_err = 1'b0;
		case (state)
			S_IDLE: begin
				// Only an idle engine takes a request, so accesses never overlap.
				if (req_in) begin // R3
					next_wr = write_in | ((target_in == TGT_NAND) && (nand_op_in != NOP_DATA));
					next_b8 = bus8_in;
					next_tgt = target_in;
					next_op = nand_op_in;
					next_sel = dec_sel;
					// I/O offsets are cut to the bank window.
					if (target_in == TGT_IO) begin
						next_addr = {{(ADDR_W - IO_OFFS_W){1'b0}}, addr_in[IO_OFFS_W-1:0]}; // R5
					end else begin
						next_addr = addr_in; // R18
					end
					// Byte mode uses only the low lane.
					next_wdat = bus8_in ? {8'h00, wdata_in[7:0]} : wdata_in; // R2
					next_be = bus8_in ? 2'b01 : be_in; // R2 R12
					if (dec_bad) begin
						// Unmapped requests finish at once with an error.
						next_sel = '0;
						next_ack = 1'b1;
						next_err = 1'b1;
					end else if (target_in == TGT_NAND) begin
						next_state = S_NWAIT;
					end else begin
						next_state = S_SETUP;
						next_cnt = SETUP_CYC;
					end
				end
			end
			S_NWAIT: begin
				// A busy NAND bank holds off the access.
				if (rb_ready) begin // R20
					next_state = S_SETUP;
					next_cnt = SETUP_CYC;
				end
			end
			S_SETUP: begin
				// Select and latch lines settle before the strobe.
				if (cnt == 4'h1) begin
					next_state = S_STROBE;
					next_cnt = STROBE_CYC;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			S_STROBE: begin
				// The strobe lasts its count and then, for memory and I/O, as long as wait is low.
				if (cnt != 4'h1) begin
					next_cnt = cnt - 4'h1;
				end else if ((tgt == TGT_NAND) || ext_wait_n_in) begin // R9
					if (!wr) begin
						next_rdata = b8 ? {8'h00, shared_data_bus_in[7:0]} : shared_data_bus_in;
					end
					next_state = S_HOLD;
					next_cnt = HOLD_CYC;
				end
			end
			S_HOLD: begin
				// Selects stay a little after the strobe rises.
				if (cnt == 4'h1) begin
					next_state = S_IDLE;
					next_ack = 1'b1;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
		// Pin values follow the next state so each pin is one flip-flop.
		active = (next_state == S_SETUP) || (next_state == S_STROBE) || (next_state == S_HOLD);
		strobe = (next_state == S_STROBE);
		mio = (next_tgt != TGT_NAND);
		next_busy = (next_state != S_IDLE);
		next_sel_n = ~(next_sel & {SEL_W{active}}); // R21 R4 R6 R15
		next_doe_n = ~(active & next_wr); // R22 R1
		next_oe_n = ~(strobe & mio & ~next_wr); // R10
		next_lo_n = ~(strobe & mio & next_wr & next_be[0]); // R12
		next_hi_n = ~(strobe & mio & next_wr & next_be[1]); // R11
		next_cle = active & ~mio & (next_op == NOP_CMD); // R13
		next_ale = active & ~mio & (next_op == NOP_ADDR); // R14
		next_re_n = ~(strobe & ~mio & ~next_wr); // R17
		next_we_n = ~(strobe & ~mio & next_wr); // R19
	end

	// Registers of the engine and of every output pin.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= S_IDLE;
			cnt <= 4'h0;
			wr <= 1'b0;
			b8 <= 1'b0;
			tgt <= TGT_MEM;
			op <= NOP_CMD;
			be <= 2'h0;
			sel <= '0;
			sel_n <= '1;
			shared_address_bus_out <= RST_ADDR;
			shared_data_bus_out <= RST_DATA;
			rdata_out <= RST_DATA;
			busy_out <= 1'b0;
			ack_out <= 1'b0;
			err_out <= 1'b0;
			shared_data_bus_oe_n_out <= 1'b1;
			ext_output_enable_n_out <= 1'b1;
			low_byte_write_n_out <= 1'b1;
			high_byte_write_n_out <= 1'b1;
			nand_cmd_latch_out <= 1'b0;
			nand_addr_latch_out <= 1'b0;
			nand_read_strobe_n_out <= 1'b1;
			nand_write_strobe_n_out <= 1'b1;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			wr <= next_wr;
			b8 <= next_b8;
			tgt <= next_tgt;
			op <= next_op;
			be <= next_be;
			sel <= next_sel;
			sel_n <= next_sel_n;
			shared_address_bus_out <= next_addr;
			shared_data_bus_out <= next_wdat;
			rdata_out <= next_rdata;
			busy_out <= next_busy;
			ack_out <= next_ack;
			err_out <= next_err;
			shared_data_bus_oe_n_out <= next_doe_n;
			ext_output_enable_n_out <= next_oe_n;
			low_byte_write_n_out <= next_lo_n;
			high_byte_write_n_out <= next_hi_n;
			nand_cmd_latch_out <= next_cle;
			nand_addr_latch_out <= next_ale;
			nand_read_strobe_n_out <= next_re_n;
			nand_write_strobe_n_out <= next_we_n;
		end
	end

	// Checks on the pins, all on the one clock.
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	one_select_a: assert property ($onehot0(~sel_n)) // R21
		else $error("More than one select is low.");
	idle_quiet_a: assert property ((state == S_IDLE) |-> (&sel_n && ext_output_enable_n_out // R21
		&& low_byte_write_n_out && high_byte_write_n_out && nand_read_strobe_n_out
		&& nand_write_strobe_n_out && !nand_cmd_latch_out && !nand_addr_latch_out))
		else $error("A select or strobe is active while idle.");
	io_window_a: assert property ((~sel_n[SEL_IO0] || ~sel_n[SEL_IO1] || ~sel_n[SEL_IO2]) // R5
		|-> (shared_address_bus_out[ADDR_W-1:IO_OFFS_W] == '0))
		else $error("I/O address leaves the bank window.");
	wait_hold_a: assert property ((state == S_STROBE && cnt == 4'h1 && tgt != TGT_NAND // R9
		&& !ext_wait_n_in) |=> (state == S_STROBE && $stable(sel_n)))
		else $error("Access ended while wait was low.");
	read_float_a: assert property (!ext_output_enable_n_out || !nand_read_strobe_n_out // R10 R22
		|-> shared_data_bus_oe_n_out)
		else $error("Data bus driven during a read.");
	write_drive_a: assert property ((!low_byte_write_n_out || !high_byte_write_n_out // R1 R19
		|| !nand_write_strobe_n_out) |-> !shared_data_bus_oe_n_out)
		else $error("Write strobe without bus drive.");
	cmd_latch_a: assert property (nand_cmd_latch_out |-> (!shared_data_bus_oe_n_out // R13
		&& !nand_addr_latch_out && !(nand_bank0_enable_n_out && nand_bank1_enable_n_out)))
		else $error("Command latch without command drive.");
	addr_latch_a: assert property ($rose(nand_addr_latch_out) // R14
		|-> (!shared_data_bus_oe_n_out && $fell(shared_data_bus_oe_n_out)))
		else $error("Address latch without address drive.");
	nand_busy_a: assert property ((state == S_NWAIT && !rb_ready) |=> (state == S_NWAIT // R20
		&& nand_bank0_enable_n_out && nand_bank1_enable_n_out))
		else $error("NAND access started while busy.");
	narrow_high_a: assert property (b8 |-> high_byte_write_n_out) // R2 R11
		else $error("High lane written in byte mode.");
	read_width_a: assert property ($fell(nand_read_strobe_n_out) // R17
		|-> (nand_read_strobe_n_out == 1'b0) [*3])
		else $error("NAND read strobe too short.");

	// The NAND write strobe lasts the whole strobe count as well.
	write_width_a: assert property ($fell(nand_write_strobe_n_out) // R19
		|-> (nand_write_strobe_n_out == 1'b0) [*3])
		else $error("NAND write strobe too short.");
	// Nothing drives the data bus while the engine rests.
	idle_float_a: assert property ((state == S_IDLE) |-> shared_data_bus_oe_n_out) // R22
		else $error("Data bus driven while idle.");
	// A completion pulse never overlaps a running access.
	ack_idle_a: assert property (ack_out |-> !busy_out) // R3
		else $error("Completion while still busy.");

endmodule
`default_nettype wire
